// [core/odc_map.svh]
`ifndef ODC_MAP_SVH
`define ODC_MAP_SVH

// ---------------------------------------------------------------
// address byte
// ---------------------------------------------------------------
`define ODC_ADDR_PREFIX   4'h9
`define ODC_BCAST_ADDR    7'h47
`define ODC_HS_CODE       5'h01

// ---------------------------------------------------------------
// select pin codes (two bits per pin)
// ---------------------------------------------------------------
`define ODC_PIN_LOW       2'h0
`define ODC_PIN_HIGH      2'h1
`define ODC_PIN_FLOAT     2'h2

// ---------------------------------------------------------------
// command nibble
// ---------------------------------------------------------------
`define ODC_CMD_LOAD      4'h0
`define ODC_CMD_UPDATE    4'h1
`define ODC_CMD_LOAD_ALL  4'h2
`define ODC_CMD_LOAD_UPD  4'h3
`define ODC_CMD_POWER     4'h4
`define ODC_CMD_CLEAR     4'h5
`define ODC_CMD_MASK      4'h6
`define ODC_CMD_SRESET    4'h7
`define ODC_CMD_REF       4'h8
`define ODC_CMD_REF_EXT   4'h9
`define ODC_ACC_ALL       4'hF
`define ODC_MASK_ALL      8'hFF
`define ODC_MASK_NONE     8'h00
`define ODC_MASK_ONE      8'h01

// ---------------------------------------------------------------
// software reset speed field (upper data bits 15:14)
// ---------------------------------------------------------------
`define ODC_SRST_DEFAULT  2'h0
`define ODC_SRST_HS_SET   2'h1
`define ODC_SRST_HS_KEEP  2'h2

// ---------------------------------------------------------------
// frame counts and buffer
// ---------------------------------------------------------------
`define ODC_BYTE_BITS     4'h8
`define ODC_ACK_BIT       4'h9
`define ODC_FIFO_DEPTH    16
`define ODC_ITEM_W        41

`endif

// [core/odc_pkg.sv]
package odc_pkg;

   // ---------------------------------------------------------------
   // frame phase
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      PH_IDLE,
      PH_ADDR,
      PH_CA,
      PH_MSB,
      PH_LSB,
      PH_TX
   } odc_phase_t;

   // ---------------------------------------------------------------
   // one executed write command
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [3:0]  cmd;
      logic [3:0]  acc;
      logic [7:0]  load_mask;
      logic [7:0]  update_mask;
      logic [15:0] data;
      logic        bcast;
   } odc_item_t;

   // ---------------------------------------------------------------
   // whole state of the serial port
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [2:0] scl_sync;
      logic [2:0] sda_sync;
      logic [3:0] pin_s1;
      logic [3:0] pin_s2;
      odc_phase_t ph;
      logic [3:0] cnt;
      logic [7:0] rx;
      logic [7:0] tx;
      logic       tx_low;
      logic       rw;
      logic       ack;
      logic       pend;
      logic       push;
      odc_item_t  item;
      logic [6:0] own_addr;
      logic       own_ok;
      logic       bcast_sel;
      logic [7:0] command_access_byte;
      logic [7:0] upper_data_byte;
      logic [7:0] rb_sel;
      logic [7:0] rb_low;
      logic       hs;
      logic       sda_oe;
      logic       sda_out;
   } odc_state_t;

endpackage

// [core/odc_fifo.sv]
module odc_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = 16
) (
   input  wire logic         ref_clk,
   input  wire logic         nrst,
   input  wire logic         in_valid,
   input  wire logic [W-1:0] in_data,
   output logic              in_ready,
   output logic              out_valid,
   output logic [W-1:0]      out_data,
   input  wire logic         out_ready
);

   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0]           wp;
      logic [AW-1:0]           rp;
      logic [AW:0]             cnt;
      logic [W-1:0]            out;
      logic                    ov;
   } odc_fifo_state_t;

   odc_fifo_state_t r_reg;
   odc_fifo_state_t r_next;
   logic            wr;
   logic            take;

   // the output register counts toward the depth
   assign in_ready  = ((r_reg.cnt + (AW+1)'(r_reg.ov)) < (AW+1)'(DEPTH));
   assign out_valid = r_reg.ov;
   assign out_data  = r_reg.out;

   // ---------------------------------------------------------------
   // storage plus a registered output word
   // ---------------------------------------------------------------
   always_comb begin
      r_next = r_reg;
      wr     = in_valid & in_ready;
      take   = (~r_reg.ov | out_ready) & (r_reg.cnt != '0);
      if (wr) begin
         r_next.mem[r_reg.wp] = in_data;
         r_next.wp = (r_reg.wp == AW'(DEPTH - 1)) ? '0 : r_reg.wp + 1'b1;
      end
      if (out_ready & r_reg.ov) begin
         r_next.ov = 1'b0;
      end
      if (take) begin
         r_next.out = r_reg.mem[r_reg.rp];
         r_next.ov  = 1'b1;
         r_next.rp  = (r_reg.rp == AW'(DEPTH - 1)) ? '0 : r_reg.rp + 1'b1;
      end
      r_next.cnt = r_reg.cnt + (AW+1)'(wr) - (AW+1)'(take);
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

endmodule

// [core/odc_port.sv]
`include "odc_map.svh"

// Operation
// - direction bit: zero writes, one reads
// - receiver acknowledges every byte on ninth clock
// - stop releases bus until start plus address
// - high-speed code unacknowledged, enters high-speed
// - repeated start continues; stop leaves high-speed
// - acknowledge holds data low through ninth high
// - execute at falling edge after lower ack
// - command byte kept; data pairs repeat it
// - address prefix 1001, low bits from pins
// - two-pin map; both floating unsupported
// - one-pin map: 000, 010, 100
// - command upper nibble, access lower nibble
// - channel load, update, load-all, load-update
// - codes four to nine are global writes
// - read select follows command and access
// - access 0-7 channels, 1111 all channels
// - broadcast accepted for writes only
// - read: command write, restart, two bytes out
// - bare read returns last written register
// - code is upper byte plus top nibble
// - access top bit set, not 1111: ignored; codes four to nine still execute
// - broadcast address is 1000111 with write
module odc_port #(
   parameter bit ONE_PIN_VARIANT = 1'b0,
   parameter int FIFO_DEPTH      = `ODC_FIFO_DEPTH
) (
   input  wire logic         ref_clk,
   input  wire logic         nrst,
   input  wire logic         scl_in,
   input  wire logic         sda_in,
   output logic              sda_out,
   output logic              sda_oe,
   input  wire logic [1:0]   addr_select_pin_low,
   input  wire logic [1:0]   addr_select_pin_high,
   output odc_pkg::odc_item_t upd_item,
   output logic              upd_valid,
   input  wire logic         upd_ready,
   output logic [7:0]        readback_select,
   input  wire logic [15:0]  readback_data,
   output logic              high_speed_operation
);

   odc_pkg::odc_state_t r_reg;
   odc_pkg::odc_state_t r_next;

   logic       scl_rise;
   logic       scl_fall;
   logic       start_cond;
   logic       stop_cond;
   logic       sda_now;
   logic [2:0] pin_bits;
   logic       pin_ok;
   logic [1:0] pin_lo;
   logic [1:0] pin_hi;
   logic [3:0] cmd;
   logic [3:0] acc;
   logic [7:0] ch_mask;
   logic [7:0] load_mask;
   logic [7:0] update_mask;
   logic       dec_ok;
   logic       addr_hit;
   logic       ackv;
   logic       fifo_in_ready;

   // ---------------------------------------------------------------
   // line conditions, taken from the second and third sync stages
   // ---------------------------------------------------------------
   assign sda_now    = r_reg.sda_sync[1];
   assign scl_rise   = r_reg.scl_sync[1] & ~r_reg.scl_sync[2];
   assign scl_fall   = ~r_reg.scl_sync[1] & r_reg.scl_sync[2];
   assign start_cond = r_reg.scl_sync[1] & r_reg.scl_sync[2]
                       & r_reg.sda_sync[2] & ~r_reg.sda_sync[1];
   assign stop_cond  = r_reg.scl_sync[1] & r_reg.scl_sync[2]
                       & ~r_reg.sda_sync[2] & r_reg.sda_sync[1];

   // ---------------------------------------------------------------
   // own address low bits from the select pins
   // ---------------------------------------------------------------
   always_comb begin
      pin_lo   = r_reg.pin_s2[1:0];
      pin_hi   = r_reg.pin_s2[3:2];
      pin_ok   = 1'b1;
      pin_bits = 3'h0;
      if (ONE_PIN_VARIANT) begin
         case (pin_lo)
            `ODC_PIN_LOW:  pin_bits = 3'h0;
            `ODC_PIN_HIGH: pin_bits = 3'h2;
            default:       pin_bits = 3'h4;
         endcase
      end else if (pin_hi[1] & pin_lo[1]) begin
         pin_ok = 1'b0;
      end else if (pin_hi[1]) begin
         pin_bits = {2'h2, pin_lo[0]};
      end else if (pin_lo[1]) begin
         pin_bits = {2'h3, pin_hi[0]};
      end else begin
         pin_bits = {1'b0, pin_hi[0], pin_lo[0]};
      end
   end

   // ---------------------------------------------------------------
   // address match: own address or write-only broadcast
   // ---------------------------------------------------------------
   assign addr_hit = (r_reg.own_ok
                      && r_reg.rx[7:1] == {`ODC_ADDR_PREFIX, r_reg.own_addr[2:0]})
                     || (r_reg.rx[7:1] == `ODC_BCAST_ADDR && !r_reg.rx[0]);

   // ---------------------------------------------------------------
   // command decode of the retained command/access byte
   // ---------------------------------------------------------------
   always_comb begin
      cmd         = r_reg.command_access_byte[7:4];
      acc         = r_reg.command_access_byte[3:0];
      load_mask   = `ODC_MASK_NONE;
      update_mask = `ODC_MASK_NONE;
      if (acc == `ODC_ACC_ALL) begin
         ch_mask = `ODC_MASK_ALL;
      end else if (!acc[3]) begin
         ch_mask = `ODC_MASK_ONE << acc[2:0];
      end else begin
         ch_mask = `ODC_MASK_NONE;
      end
      case (cmd)
         `ODC_CMD_LOAD: begin
            load_mask = ch_mask;
            dec_ok    = (ch_mask != `ODC_MASK_NONE);
         end
         `ODC_CMD_UPDATE: begin
            update_mask = ch_mask;
            dec_ok      = (ch_mask != `ODC_MASK_NONE);
         end
         `ODC_CMD_LOAD_ALL: begin
            load_mask   = ch_mask;
            update_mask = `ODC_MASK_ALL;
            dec_ok      = (ch_mask != `ODC_MASK_NONE);
         end
         `ODC_CMD_LOAD_UPD: begin
            load_mask   = ch_mask;
            update_mask = ch_mask;
            dec_ok      = (ch_mask != `ODC_MASK_NONE);
         end
         `ODC_CMD_POWER, `ODC_CMD_CLEAR, `ODC_CMD_MASK,
         `ODC_CMD_SRESET, `ODC_CMD_REF, `ODC_CMD_REF_EXT: begin
            dec_ok = 1'b1;
         end
         default: begin
            dec_ok = 1'b0;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // serial frame engine
   // ---------------------------------------------------------------
   always_comb begin
      r_next          = r_reg;
      ackv            = 1'b0;
      r_next.push     = 1'b0;
      r_next.sda_out  = 1'b0;
      r_next.scl_sync = {r_reg.scl_sync[1:0], scl_in};
      r_next.sda_sync = {r_reg.sda_sync[1:0], sda_in};
      r_next.pin_s1   = {addr_select_pin_high, addr_select_pin_low};
      r_next.pin_s2   = r_reg.pin_s1;

      if (stop_cond) begin
         r_next.ph     = odc_pkg::PH_IDLE;
         r_next.sda_oe = 1'b0;
         r_next.hs     = 1'b0;
         r_next.pend   = 1'b0;
      end else if (start_cond) begin
         r_next.ph       = odc_pkg::PH_ADDR;
         r_next.cnt      = 4'h0;
         r_next.sda_oe   = 1'b0;
         r_next.pend     = 1'b0;
         r_next.own_addr = {`ODC_ADDR_PREFIX, pin_bits};
         r_next.own_ok   = pin_ok;
      end else if (r_reg.ph != odc_pkg::PH_IDLE) begin
         if (scl_rise) begin
            if (r_reg.cnt < `ODC_BYTE_BITS) begin
               r_next.rx  = {r_reg.rx[6:0], sda_now};
               r_next.cnt = r_reg.cnt + 4'h1;
            end else if (r_reg.cnt == `ODC_BYTE_BITS) begin
               r_next.cnt = `ODC_ACK_BIT;
               if (r_reg.ph == odc_pkg::PH_TX) begin
                  r_next.ack = ~sda_now;
               end
            end
         end else if (scl_fall) begin
            if (r_reg.cnt == `ODC_BYTE_BITS) begin
               // byte complete: decide the acknowledge
               case (r_reg.ph)
                  odc_pkg::PH_ADDR: begin
                     if (r_reg.rx[7:3] == `ODC_HS_CODE) begin
                        r_next.hs = 1'b1;
                        r_next.ph = odc_pkg::PH_IDLE;
                     end else if (addr_hit) begin
                        ackv             = 1'b1;
                        r_next.rw        = r_reg.rx[0];
                        r_next.bcast_sel = (r_reg.rx[7:1] == `ODC_BCAST_ADDR);
                     end else begin
                        r_next.ph = odc_pkg::PH_IDLE;
                     end
                  end
                  odc_pkg::PH_CA: begin
                     r_next.command_access_byte = r_reg.rx;
                     r_next.rb_sel              = r_reg.rx;
                     ackv                       = 1'b1;
                  end
                  odc_pkg::PH_MSB: begin
                     r_next.upper_data_byte = r_reg.rx;
                     ackv                   = 1'b1;
                  end
                  odc_pkg::PH_LSB: begin
                     // a full buffer refuses the pair
                     ackv        = fifo_in_ready;
                     r_next.pend = fifo_in_ready & dec_ok;
                     r_next.item.cmd         = cmd;
                     r_next.item.acc         = acc;
                     r_next.item.load_mask   = load_mask;
                     r_next.item.update_mask = update_mask;
                     r_next.item.data  = {r_reg.upper_data_byte, r_reg.rx[7:4], 4'h0};
                     r_next.item.bcast = r_reg.bcast_sel;
                  end
                  default: begin
                     ackv = 1'b0;
                  end
               endcase
               r_next.ack    = ackv;
               r_next.sda_oe = ackv;
            end else if (r_reg.cnt == `ODC_ACK_BIT) begin
               // end of the acknowledge clock
               r_next.cnt    = 4'h0;
               r_next.sda_oe = 1'b0;
               case (r_reg.ph)
                  odc_pkg::PH_ADDR: begin
                     if (r_reg.rw) begin
                        r_next.ph     = odc_pkg::PH_TX;
                        r_next.tx     = readback_data[15:8];
                        r_next.rb_low = readback_data[7:0];
                        r_next.tx_low = 1'b0;
                        r_next.sda_oe = ~readback_data[15];
                     end else begin
                        r_next.ph = odc_pkg::PH_CA;
                     end
                  end
                  odc_pkg::PH_CA: begin
                     r_next.ph = odc_pkg::PH_MSB;
                  end
                  odc_pkg::PH_MSB: begin
                     r_next.ph = odc_pkg::PH_LSB;
                  end
                  odc_pkg::PH_LSB: begin
                     r_next.ph   = odc_pkg::PH_MSB;
                     r_next.pend = 1'b0;
                     if (r_reg.pend) begin
                        r_next.push = 1'b1;
                        if (r_reg.item.cmd == `ODC_CMD_SRESET) begin
                           case (r_reg.item.data[15:14])
                              `ODC_SRST_HS_SET:  r_next.hs = 1'b1;
                              `ODC_SRST_HS_KEEP: r_next.hs = r_reg.hs;
                              default:           r_next.hs = 1'b0;
                           endcase
                        end
                     end
                  end
                  odc_pkg::PH_TX: begin
                     if (!r_reg.ack) begin
                        r_next.ph = odc_pkg::PH_IDLE;
                     end else if (!r_reg.tx_low) begin
                        r_next.tx     = r_reg.rb_low;
                        r_next.tx_low = 1'b1;
                        r_next.sda_oe = ~r_reg.rb_low[7];
                     end else begin
                        r_next.tx     = readback_data[15:8];
                        r_next.rb_low = readback_data[7:0];
                        r_next.tx_low = 1'b0;
                        r_next.sda_oe = ~readback_data[15];
                     end
                  end
                  default: begin
                     r_next.ph = odc_pkg::PH_IDLE;
                  end
               endcase
            end else if (r_reg.ph == odc_pkg::PH_TX && r_reg.cnt != 4'h0) begin
               r_next.tx     = {r_reg.tx[6:0], 1'b0};
               r_next.sda_oe = ~r_reg.tx[6];
            end
         end
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   // ---------------------------------------------------------------
   // executed commands wait here for the register core
   // ---------------------------------------------------------------
   odc_fifo #(
      .W     (`ODC_ITEM_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .ref_clk   (ref_clk),
      .nrst      (nrst),
      .in_valid  (r_reg.push),
      .in_data   (r_reg.item),
      .in_ready  (fifo_in_ready),
      .out_valid (upd_valid),
      .out_data  (upd_item),
      .out_ready (upd_ready)
   );

   assign sda_out              = r_reg.sda_out;
   assign sda_oe               = r_reg.sda_oe;
   assign readback_select      = r_reg.rb_sel;
   assign high_speed_operation = r_reg.hs;

endmodule

// [tb/odc_ctl_model.sv]
module odc_ctl_model (
   input  wire logic ref_clk,
   input  wire logic sda_in,
   output logic      scl_pull,
   output logic      sda_pull
);
   timeunit 1ns;
   timeprecision 100ps;
   // ---
   // bus controller, pull high means the line is held low
   // ---
   initial begin
      scl_pull = 1'h0;
      sda_pull = 1'h0;
   end
   task automatic tw(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic drv(input int n, input logic c, input logic d);
      tw(n);
      scl_pull = c;
      sda_pull = d;
   endtask
   // data settles mid-low, sampled at the end of the high phase
   task automatic clk_bit(input logic d, output logic s);
      drv(2, 1'h1, !d);
      drv(2, 1'h0, !d);
      tw(4);
      s = sda_in;
      scl_pull = 1'h1;
   endtask
   // start or repeated start, data released first
   task automatic start();
      drv(2, 1'h1, 1'h0);
      drv(2, 1'h0, 1'h0);
      drv(4, 1'h0, 1'h1);
      drv(4, 1'h1, 1'h1);
   endtask
   // data rises while the clock is high
   task automatic stop();
      drv(2, 1'h1, 1'h1);
      drv(2, 1'h0, 1'h1);
      drv(4, 1'h0, 1'h0);
      tw(4);
   endtask
   task automatic wbyte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
      clk_bit(1'h1, s);
      ack = !s;
   endtask
   task automatic rbyte(input logic ack, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) clk_bit(1'h1, b[i]);
      clk_bit(!ack, s);
   endtask
endmodule

// [tb/odc_port_asserts.sv]
module odc_port_asserts #(
   parameter bit ONE_PIN_VARIANT = 1'h0,
   parameter int FIFO_DEPTH      = 16
) (
   input wire logic               ref_clk,
   input wire logic               nrst,
   input wire logic               scl_in,
   input wire logic               sda_in,
   input wire logic               sda_out,
   input wire logic               sda_oe,
   input wire logic [1:0]         addr_select_pin_low,
   input wire logic [1:0]         addr_select_pin_high,
   input wire odc_pkg::odc_item_t upd_item,
   input wire logic               upd_valid,
   input wire logic               upd_ready,
   input wire logic [7:0]         readback_select,
   input wire logic [15:0]        readback_data,
   input wire logic               high_speed_operation
);
   timeunit 1ns;
   timeprecision 100ps;
   logic       oe_d_reg;
   logic [3:0] since_reg;
   // ---
   // cycles since the device let go of the data line
   // ---
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         oe_d_reg  <= 1'h0;
         since_reg <= 4'hF;
      end else begin
         oe_d_reg <= sda_oe;
         if (oe_d_reg && !sda_oe) since_reg <= 4'h0;
         else if (since_reg != 4'hF) since_reg <= since_reg + 4'h1;
      end
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   a_oe_open_drain: assert property (sda_oe |-> !sda_out)
      else $error("data pin driven high");
   a_oe_steady_high: assert property (scl_in && $past(scl_in, 2) |-> $stable(sda_oe))
      else $error("data drive moved while clock high");
   a_item_hold: assert property (upd_valid && !upd_ready |=> upd_valid && $stable(upd_item))
      else $error("update item changed before taken");
   a_low_nibble: assert property (upd_valid |-> upd_item.data[3:0] == 4'h0)
      else $error("unused data bits not zero");
   a_bad_access: assert property (upd_valid && upd_item.cmd < 4'h4 |-> !upd_item.acc[3] || upd_item.acc == 4'hF)
      else $error("invalid access executed");
   a_hs_no_ack: assert property ($rose(high_speed_operation) |-> !sda_oe [*8])
      else $error("high speed code acknowledged");
   a_stop_ends_hs: assert property (scl_in && $rose(sda_in) |-> ##[1:6] !high_speed_operation)
      else $error("high speed kept after stop");
   a_exec_after_ack: assert property ($rose(upd_valid) |-> sda_oe || since_reg < 4'h5)
      else $error("update not at end of acknowledge");
   c_hs: cover property ($rose(high_speed_operation));
   c_stall: cover property (upd_valid && !upd_ready ##1 upd_ready);
   c_ack: cover property ($rose(sda_oe));
endmodule
bind odc_port odc_port_asserts #(
   .ONE_PIN_VARIANT(ONE_PIN_VARIANT), .FIFO_DEPTH(FIFO_DEPTH)
) odc_port_asserts_inst (
   .ref_clk(ref_clk), .nrst(nrst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
   .sda_oe(sda_oe), .addr_select_pin_low(addr_select_pin_low),
   .addr_select_pin_high(addr_select_pin_high), .upd_item(upd_item), .upd_valid(upd_valid),
   .upd_ready(upd_ready), .readback_select(readback_select), .readback_data(readback_data),
   .high_speed_operation(high_speed_operation)
);

// [tb/tb_top.sv]
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
`define CHK(a, e) check_eq(64'(a), 64'(e))
   logic               ref_clk, nrst, scl_pull, sda_pull, sda_out, sda_oe, hold, hs, ack;
   logic               upd_valid, upd_ready;
   logic [1:0]         pin_lo, pin_hi;
   logic [7:0]         rb_sel, b0, b1, ca;
   logic [15:0]        rb_data;
   logic [6:0]         my;
   int                 num_errors, total_checks;
   odc_pkg::odc_item_t upd_item;
   odc_pkg::odc_item_t exp_q[$];
   wire                scl_in = !scl_pull;
   wire                sda_in = !(sda_oe | sda_pull);
   odc_port odc_port_inst (
      .ref_clk(ref_clk), .nrst(nrst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
      .sda_oe(sda_oe), .addr_select_pin_low(pin_lo), .addr_select_pin_high(pin_hi),
      .upd_item(upd_item), .upd_valid(upd_valid), .upd_ready(upd_ready),
      .readback_select(rb_sel), .readback_data(rb_data), .high_speed_operation(hs)
   );
   odc_ctl_model odc_ctl_model_inst (
      .ref_clk(ref_clk), .sda_in(sda_in), .scl_pull(scl_pull), .sda_pull(sda_pull)
   );
   initial begin
      ref_clk = 1'h0;
      forever #50 ref_clk = !ref_clk;
   end
   task automatic check_eq(input logic [63:0] a, input logic [63:0] e);
      total_checks++;
      if (a !== e) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, a, e);
      end
   endtask
   task automatic final_report();
      $display("checks=%0d errors=%0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic st();
      odc_ctl_model_inst.start();
   endtask
   task automatic sp();
      odc_ctl_model_inst.stop();
   endtask
   task automatic put(input logic [7:0] b, input logic e);
      odc_ctl_model_inst.wbyte(b, ack);
      `CHK(ack, e);
   endtask
   function automatic logic [6:0] adr(input logic [1:0] lo, input logic [1:0] hi);
      if (hi[1]) return {4'h9, 3'h4 | 3'(lo[0])};
      if (lo[1]) return {4'h9, 3'h6 | 3'(hi[0])};
      return {4'h9, 1'h0, hi[0], lo[0]};
   endfunction
   function automatic odc_pkg::odc_item_t mk(input logic [7:0] c, input logic bc);
      logic [7:0] s;
      s = (c[3:0] == 4'hF) ? 8'hFF : 8'h01 << c[2:0];
      mk = '{c[7:4], c[3:0], 8'h00, 8'h00, {b0, b1[7:4], 4'h0}, bc};
      if (c[7:4] inside {4'h0, 4'h2, 4'h3}) mk.load_mask = s;
      if (c[7:4] inside {4'h1, 4'h3}) mk.update_mask = s;
      if (c[7:4] == 4'h2) mk.update_mask = 8'hFF;
   endfunction
   task automatic pair(input logic [7:0] c, input logic [7:0] m, input logic bc, input logic e);
      b0 = 8'($urandom) & m;
      b1 = 8'($urandom);
      put(b0, 1'h1);
      put(b1, e);
      if (e && c[7:4] < 4'hA && (c[7:4] > 4'h3 || !c[3] || c[3:0] == 4'hF))
         exp_q.push_back(mk(c, bc));
   endtask
   task automatic tend(input int n);
      for (int k = 0; k < 3000 && exp_q.size() > 0; k++) odc_ctl_model_inst.tw(1);
      if (exp_q.size() > 0) begin
         num_errors++;
         final_report();
      end else begin
         $display("test %0d done, errors %0d", n, num_errors);
      end
   endtask
   // ---
   // random consumer stalls, and the update stream monitor
   // ---
   initial forever begin
      @(posedge ref_clk);
      #1;
      upd_ready = hold ? 1'h0 : 1'($urandom);
   end
   always @(posedge ref_clk) begin
      odc_pkg::odc_item_t e;
      if (upd_valid === 1'h1 && upd_ready === 1'h1) begin
         e = '1;
         if (exp_q.size() > 0) e = exp_q.pop_front();
         `CHK(upd_item, e);
      end
   end
   initial begin
      {nrst, hold, pin_lo, pin_hi, rb_data} = '0;
      void'($urandom(32'h2ca3_ced4));
      repeat (8) @(posedge ref_clk);
      #1 nrst = 1'h1;
      for (int i = 0; i < 8; i++) begin
         {pin_lo, pin_hi} = {2'(i % 3), 2'(i / 3)};
         my = adr(pin_lo, pin_hi);
         ca = {4'(i % 4), (i == 7) ? 4'hF : 4'(i)};
         odc_ctl_model_inst.tw(6);
         st();
         put({my, 1'h0}, 1'h1);
         put(ca, 1'h1);
         repeat (2) pair(ca, 8'hFF, 1'h0, 1'h1);
         st();
         put({my ^ 7'h01, 1'h0}, 1'h0);
         sp();
      end
      tend(1);
      for (int c = 4; c < 11; c++) begin
         st();
         put({my, 1'h0}, 1'h1);
         put({4'(c), 4'h0}, 1'h1);
         pair({4'(c), 4'h0}, 8'h3F, 1'h0, 1'h1);
      end
      st();
      put({my, 1'h0}, 1'h1);
      put(8'h09, 1'h1);
      pair(8'h09, 8'hFF, 1'h0, 1'h1);
      st();
      put({7'h47, 1'h0}, 1'h1);
      put(8'h3F, 1'h1);
      pair(8'h3F, 8'hFF, 1'h1, 1'h1);
      st();
      put({7'h47, 1'h1}, 1'h0);
      sp();
      tend(2);
      for (int r = 0; r < 2; r++) begin
         rb_data = 16'($urandom);
         st();
         if (r == 0) put({my, 1'h0}, 1'h1);
         if (r == 0) put(8'h13, 1'h1);
         if (r == 0) st();
         put({my, 1'h1}, 1'h1);
         odc_ctl_model_inst.rbyte(1'h1, b0);
         odc_ctl_model_inst.rbyte(1'h0, b1);
         sp();
         `CHK({b0, b1}, rb_data);
         `CHK(rb_sel, 8'h13);
      end
      tend(3);
      st();
      put(8'h09, 1'h0);
      `CHK(hs, 1'h1);
      st();
      put({my, 1'h0}, 1'h1);
      put(8'h32, 1'h1);
      put(8'h55, 1'h1);
      st();
      put({my, 1'h0}, 1'h1);
      put(8'h35, 1'h1);
      pair(8'h35, 8'hFF, 1'h0, 1'h1);
      sp();
      odc_ctl_model_inst.tw(2);
      `CHK(hs, 1'h0);
      tend(4);
      hold = 1'h1;
      st();
      put({my, 1'h0}, 1'h1);
      put(8'h01, 1'h1);
      for (int k = 0; k < 17; k++) pair(8'h01, 8'hFF, 1'h0, k < 16);
      sp();
      hold = 1'h0;
      tend(5);
      final_report();
   end
endmodule
